// ==== dv/ibus_port_asserts.sv ====
// Purpose : wire-level checks on the bus between both ends
// Assumes : inputs come straight from the carrier interface
// Notes   : sync delays keep every bound loose on purpose
`timescale 1ns/10ps
module ibus_port_asserts import ibus_pkg::*; (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [NLINES-1:0] devOe,
  input wire logic [NLINES-1:0] ctlOe,
  input wire logic [NLINES-1:0] lineLow
);
  // ----------------------------------------
  // handshake properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a source keeps its byte still while data valid stands
  ctl_hold_a: assert property (
    ctlOe[L_DAV] && $past(ctlOe[L_DAV]) && !ctlOe[L_IFC]
    |-> $stable({ctlOe[L_ATN], ctlOe[L_EOI], ctlOe[7:0]})) else $error("ctl byte moved");
  dev_hold_a: assert property (
    devOe[L_DAV] && $past(devOe[L_DAV]) |-> $stable({devOe[L_EOI], devOe[7:0]}))
    else $error("dev byte moved");
  // data valid only once every acceptor is ready
  ctl_order_a: assert property (
    $rose(ctlOe[L_DAV]) |-> !$past(lineLow[L_NRFD])) else $error("dav before ready");
  ctl_release_a: assert property (
    $fell(ctlOe[L_DAV]) && !ctlOe[L_IFC] |-> !$past(lineLow[L_NDAC]))
    else $error("ctl dav dropped early");
  dev_release_a: assert property (
    $fell(devOe[L_DAV]) && !lineLow[L_IFC] |-> !$past(lineLow[L_NDAC]))
    else $error("dev dav dropped early");
  // the acceptor re-arms only after data valid is gone
  dev_rearm_a: assert property (
    $fell(devOe[L_NRFD]) && !lineLow[L_IFC] |-> !$past(lineLow[L_DAV]))
    else $error("rearm under dav");
  ifc_idle_a: assert property (
    ctlOe[L_IFC] [*6] |-> devOe[L_DAV:0] == '0) else $error("busy under clear");
  one_talker_a: assert property (
    !(devOe[L_DAV] && ctlOe[L_DAV])) else $error("two talkers");
endmodule : ibus_port_asserts

// ==== dv/instrument_bus_device_port_bench.sv ====
// Purpose : drives both ends of the bus and checks the traffic
// Assumes : one clock; device address random in 0..15
// Notes   : drivers queue expected bytes, the monitor pops them
`timescale 1ns/10ps
module instrument_bus_device_port_bench import ibus_pkg::*;;
  logic       clk_sys, reset_n, serviceReq, rxReady, txValid, txLast, hold, cmdValid;
  logic       cmdAtn, cmdEoi, listenEn, ifcReq, renReq, pollReq, pollValid, cRxValid;
  logic       dRxValid, dRxLast, cRxLast, txReady, cmdReady, listenActive, talkActive;
  logic       remoteMode, secondaryValid, devClear, ifcActive;
  logic [7:0] txData, cmdData, dRxData, cRxData, pollData;
  logic [4:0] addr, secondaryCode;
  logic [8:0] dq[$], cq[$], b;
  int         n_errors, check_count, cyc, nclr, nsec, i, seed;

  ibus_if bus ();
  ibus_device ibus_device_i (.clk_sys, .reset_n, .bus(bus), .busAddr(addr), .serviceReq,
    .rxValid(dRxValid), .rxData(dRxData), .rxLast(dRxLast), .rxReady, .txValid, .txData,
    .txLast, .txReady, .listenActive, .talkActive, .remoteMode, .secondaryValid,
    .secondaryCode, .devClear, .ifcActive);
  ibus_controller ibus_controller_i (.clk_sys, .reset_n, .bus(bus), .cmdValid, .cmdData,
    .cmdAtn, .cmdEoi, .cmdReady, .listenEn, .rxValid(cRxValid), .rxData(cRxData),
    .rxLast(cRxLast), .ifcReq, .renReq, .pollReq, .pollValid, .pollData);
  ibus_port_asserts ibus_port_asserts_i (.clk_sys, .reset_n, .devOe(bus.devOe),
    .ctlOe(bus.ctlOe), .lineLow(bus.lineLow));

  // ----------------------------------------
  // clock, tasks and monitor
  // ----------------------------------------
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  // one idle edge after each byte so valid never toggles twice at once
  task send(input logic [7:0] d, input logic a, input logic e);
    cmdData = d;
    cmdAtn = a;
    cmdEoi = e;
    cmdValid = 1;
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    #1 cmdValid = 0;
    wt(1);
  endtask : send
  task tx(input logic [8:0] d);
    {txLast, txData} = d;
    txValid = 1;
    do @(posedge clk_sys); while (txReady !== 1'b1);
    #1 txValid = 0;
    wt(1);
  endtask : tx
  task report_and_stop();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // random reader stalls unless held off completely
  always @(posedge clk_sys) #1 rxReady = hold ? 1'b0 : 1'($random(seed));
  // results are compared against the oldest queued note
  always @(posedge clk_sys) begin
    if (dRxValid === 1'b1 && rxReady === 1'b1) chk({dRxLast, dRxData}, dq.pop_front());
    if (cRxValid === 1'b1) chk({cRxLast, cRxData}, cq.pop_front());
    if (devClear === 1'b1) nclr++;
    if (secondaryValid === 1'b1) nsec++;
    if (++cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h862408C5;
    {reset_n, serviceReq, txValid, txLast, cmdValid, cmdAtn, cmdEoi, rxReady} = '0;
    {listenEn, ifcReq, renReq, pollReq, txData, cmdData} = '0;
    hold = 1;
    addr = 5'($random(seed)) & 5'h0F;
    wt(5);
    reset_n = 1;
    wt(2);
    send(8'h20 | 8'(addr), 1'b1, 1'b0);
    // nonzero code, so the later clear has something to wipe
    b = (9'($random(seed)) & 9'h00F) | 9'h010;
    send(8'h60 | b[7:0], 1'b1, 1'b0);
    wt(20);
    chk(9'(listenActive), 9'h001);
    chk(9'(secondaryCode), b);
    chk(9'(nsec), 9'h001);
    // nine text bytes against a full buffer
    fork
      for (i = 0; i < 9; i++) begin
        b = {i == 8, 8'($random(seed))};
        dq.push_back(b);
        send(b[7:0], 1'b0, b[8]);
      end
      begin
        wt(200);
        chk(9'(bus.devOe[L_NRFD]), 9'h001);
        hold = 0;
      end
    join
    wait (dq.size() == 0);
    wt(1);
    send({1'($random(seed)), 7'h14}, 1'b1, 1'b0);
    wt(20);
    chk(9'(nclr), 9'h001);
    chk(9'(secondaryCode), 9'h000);
    send(8'h3F, 1'b1, 1'b0);
    wt(20);
    chk(9'(listenActive), 9'h000);
    send(8'h40 | 8'(addr), 1'b1, 1'b0);
    wt(20);
    chk(9'(talkActive), 9'h001);
    listenEn = 1;
    for (i = 0; i < 3; i++) begin
      b = {i == 2, 8'($random(seed))};
      cq.push_back(b);
      tx(b);
    end
    wait (cq.size() == 0);
    wt(1);
    listenEn = 0;
    send(8'h40 | 8'(addr ^ 5'h01), 1'b1, 1'b0);
    wt(20);
    chk(9'(talkActive), 9'h000);
    send(8'h5F, 1'b1, 1'b0);
    // let the untalk byte finish; a poll request would abort it mid-handshake
    wt(20);
    // poll with and then without a service request
    for (i = 1; i >= 0; i--) begin
      serviceReq = i[0];
      pollReq = 1;
      do @(posedge clk_sys); while (pollValid !== 1'b1);
      #1 chk(9'(pollData[addr[2:0]]), 9'(i));
      pollReq = 0;
      wt(20);
    end
    renReq = 1;
    send(8'h20 | 8'(addr), 1'b1, 1'b0);
    wt(20);
    chk(9'(remoteMode), 9'h001);
    ifcReq = 1;
    wt(20);
    chk({6'h00, ifcActive, listenActive, talkActive}, 9'h004);
    ifcReq = 0;
    wt(20);
    report_and_stop();
  end
endmodule : instrument_bus_device_port_bench

// ==== hw/ibus_controller.sv ====
// Purpose : controller-in-charge end of the instrument bus
// Assumes : user queues command and text bytes; bus lines arrive asynchronously
// Notes   : attention follows the kind of the byte being sent
`timescale 1ns/10ps
module ibus_controller import ibus_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  ibus_if.ctrl            bus,
  input  wire logic       cmdValid,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdAtn,
  input  wire logic       cmdEoi,
  output logic            cmdReady,
  input  wire logic       listenEn,
  output logic            rxValid,
  output logic      [7:0] rxData,
  output logic            rxLast,
  input  wire logic       ifcReq,
  input  wire logic       renReq,
  input  wire logic       pollReq,
  output logic            pollValid,
  output logic      [7:0] pollData
);
  logic [NLINES-1:0] s1Q;
  logic [NLINES-1:0] s2Q;
  logic [NLINES-1:0] oeD;
  logic [NLINES-1:0] oeQ;
  src_e              srcQ;
  acc_e              accQ;
  logic [7:0]        byteQ;
  logic              eoiQ;
  logic              atnQ;
  logic              readyQ;
  logic              rxValidQ;
  logic [7:0]        rxDataQ;
  logic              rxLastQ;
  logic [2:0]        pollCntQ;
  logic              pollValidQ;
  logic [7:0]        pollDataQ;
  logic              pollOn;
  logic              accOn;
  logic              load;

  // ------------------------------------------------------------------
  // line synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1Q <= '0;
      s2Q <= '0;
    end else begin
      s1Q <= bus.lineLow;
      s2Q <= s1Q;
    end
  end

  assign pollOn = pollReq && !ifcReq && (srcQ == SRC_IDLE);
  assign accOn  = listenEn && !atnQ && !ifcReq && !pollReq && (srcQ == SRC_IDLE);
  assign load   = (srcQ == SRC_IDLE) && cmdValid && readyQ;

  // ------------------------------------------------------------------
  // source handshake and attention
  // ------------------------------------------------------------------
  // attention is held across command bytes and dropped for text
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      srcQ   <= SRC_IDLE;
      byteQ  <= '0;
      eoiQ   <= 1'b0;
      atnQ   <= 1'b0;
      readyQ <= 1'b0;
    end else if (ifcReq || pollReq) begin
      srcQ   <= SRC_IDLE;
      readyQ <= 1'b0;
    end else begin
      unique case (srcQ)
        SRC_IDLE: begin
          readyQ <= !load;
          if (load) begin
            byteQ <= cmdData;
            eoiQ  <= cmdEoi;
            atnQ  <= cmdAtn;
            srcQ  <= SRC_SETUP;
          end else if (listenEn && !cmdValid) begin
            atnQ <= 1'b0;
          end
        end
        SRC_SETUP: if (!s2Q[L_NRFD] && s2Q[L_NDAC]) srcQ <= SRC_DAV;
        SRC_DAV:   if (!s2Q[L_NDAC]) srcQ <= SRC_IDLE;
        default:   srcQ <= SRC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // acceptor handshake, always ready
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      accQ     <= ACC_WAIT;
      rxValidQ <= 1'b0;
      rxDataQ  <= '0;
      rxLastQ  <= 1'b0;
    end else begin
      rxValidQ <= 1'b0;
      if (!accOn) begin
        accQ <= ACC_WAIT;
      end else begin
        unique case (accQ)
          ACC_WAIT: accQ <= ACC_RDY;
          ACC_RDY: begin
            if (s2Q[L_DAV]) begin
              accQ     <= ACC_DONE;
              rxValidQ <= 1'b1;
              rxDataQ  <= s2Q[L_DIO0 +: 8];
              rxLastQ  <= s2Q[L_EOI];
            end
          end
          ACC_DONE: if (!s2Q[L_DAV]) accQ <= ACC_WAIT;
          default:  accQ <= ACC_WAIT;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // parallel poll sampling
  // ------------------------------------------------------------------
  // responders need a few cycles to see attention with end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pollCntQ   <= '0;
      pollValidQ <= 1'b0;
      pollDataQ  <= '0;
    end else if (!pollOn) begin
      pollCntQ   <= '0;
      pollValidQ <= 1'b0;
    end else begin
      if (pollCntQ != POLL_SETTLE) pollCntQ <= pollCntQ + 3'h1;
      pollValidQ <= (pollCntQ == POLL_SETTLE);
      pollDataQ  <= s2Q[L_DIO0 +: 8];
    end
  end

  // ------------------------------------------------------------------
  // line drive
  // ------------------------------------------------------------------
  always_comb begin
    oeD = '0;
    if (srcQ != SRC_IDLE) begin
      oeD[L_DIO0 +: 8] = byteQ;
      oeD[L_EOI]       = eoiQ;
    end
    oeD[L_DAV] = (srcQ == SRC_DAV);
    oeD[L_ATN] = atnQ || pollOn;
    if (pollOn) oeD[L_EOI] = 1'b1;
    if (accOn) begin
      oeD[L_NRFD] = (accQ != ACC_RDY);
      oeD[L_NDAC] = (accQ != ACC_DONE);
    end
    oeD[L_IFC] = ifcReq;
    oeD[L_REN] = renReq;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) oeQ <= '0;
    else oeQ <= oeD;
  end

  assign bus.ctlO  = '0;
  assign bus.ctlOe = oeQ;
  assign cmdReady  = readyQ;
  assign rxValid   = rxValidQ;
  assign rxData    = rxDataQ;
  assign rxLast    = rxLastQ;
  assign pollValid = pollValidQ;
  assign pollData  = pollDataQ;
endmodule : ibus_controller

// ==== hw/ibus_device.sv ====
// Purpose : device end of the instrument bus with receive buffer
// Assumes : bus lines arrive asynchronously; busAddr is stable at reset release
// Notes   : handshake is slow by design, one sync delay per step
//
// Function
// - bytes paced by three handshake lines only
// - one byte at a time, eight parallel lines
// - each handshake step waits for previous step
// - transfer waits for slowest listener
// - accept every byte while attention is low
// - unaddressed device ignores data lines
// - other talk address drops our talker state
// - interface clear forces functions idle
// - remote enable selects bus or panel
// - end flag marks last byte of transfer
// - attention with end triggers poll response
// - universal commands decoded regardless of addressing
// - message opens with listen or talk primary
// - message closes with unlisten or untalk
// - secondary byte selects text action
// - multi-byte device commands come as text
// - fixed bus address compared against primaries
// - poll answered only when service requested
// - controller holds attention over command bytes
// - device clear discards stored controller information
`timescale 1ns/10ps

// ------------------------------------------------------------------
// fifo buffer
// ------------------------------------------------------------------
module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0]    wrPtrQ;
  logic [AW-1:0]    rdPtrQ;
  logic [AW:0]      countQ;
  logic             push;
  logic             pop;

  assign inReady  = countQ != (AW+1)'(DEPTH);
  assign outValid = countQ != '0;
  assign outData  = memQ[rdPtrQ];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage, written only at the write pointer
  always_ff @(posedge clk_sys) begin
    if (push) begin
      memQ[wrPtrQ] <= inData;
    end
  end

  // pointers and fill level; flush empties without touching storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else if (flush) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (push) wrPtrQ <= wrPtrQ + AW'(1);
      if (pop) rdPtrQ <= rdPtrQ + AW'(1);
      if (push && !pop) countQ <= countQ + (AW+1)'(1);
      else if (pop && !push) countQ <= countQ - (AW+1)'(1);
    end
  end
endmodule : fifo_buf

// ------------------------------------------------------------------
// device end
// ------------------------------------------------------------------
module ibus_device import ibus_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  ibus_if.device                 bus,
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic              serviceReq,
  output logic                   rxValid,
  output logic      [7:0]        rxData,
  output logic                   rxLast,
  input  wire logic              rxReady,
  input  wire logic              txValid,
  input  wire logic [7:0]        txData,
  input  wire logic              txLast,
  output logic                   txReady,
  output logic                   listenActive,
  output logic                   talkActive,
  output logic                   remoteMode,
  output logic                   secondaryValid,
  output logic      [4:0]        secondaryCode,
  output logic                   devClear,
  output logic                   ifcActive
);
  logic [NLINES-1:0] s1Q;
  logic [NLINES-1:0] s2Q;
  logic [NLINES-1:0] oeD;
  logic [NLINES-1:0] oeQ;
  logic [ADDR_W-1:0] addrQ;
  logic              cfgQ;
  acc_e              accQ;
  src_e              srcQ;
  logic              ladQ;
  logic              tadQ;
  logic              mineQ;
  logic              secValidQ;
  logic [4:0]        secCodeQ;
  logic              devClrQ;
  logic              remoteQ;
  logic [7:0]        txByteQ;
  logic              txEoiQ;
  logic              txReadyQ;
  logic              davS, nrfdS, ndacS, eoiS, atnS, ifcS, renS, ppS;
  logic [7:0]        dioS;
  logic [6:0]        cmd;
  logic              accActive;
  logic              take;
  logic              cmdTake;
  logic              rxPush;
  logic              rxInReady;
  logic              talkOk;
  logic [RX_WIDTH-1:0] rxWord;

  // ------------------------------------------------------------------
  // line synchronisers
  // ------------------------------------------------------------------
  // two stages; only the second stage is read anywhere
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1Q <= '0;
      s2Q <= '0;
    end else begin
      s1Q <= bus.lineLow;
      s2Q <= s1Q;
    end
  end

  assign dioS  = s2Q[L_DIO0 +: 8];
  assign davS  = s2Q[L_DAV];
  assign nrfdS = s2Q[L_NRFD];
  assign ndacS = s2Q[L_NDAC];
  assign eoiS  = s2Q[L_EOI];
  assign atnS  = s2Q[L_ATN];
  assign ifcS  = s2Q[L_IFC];
  assign renS  = s2Q[L_REN];
  assign ppS   = atnS && eoiS && !ifcS;
  assign cmd   = dioS[6:0];              // parity bit ignored

  // address strap caught once after reset release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfgQ  <= 1'b0;
      addrQ <= '0;
    end else if (!cfgQ) begin
      cfgQ  <= 1'b1;
      addrQ <= busAddr;
    end
  end

  // ------------------------------------------------------------------
  // acceptor handshake
  // ------------------------------------------------------------------
  // listens to every byte under attention, else only when addressed
  assign accActive = !ifcS && cfgQ && (atnS || ladQ);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      accQ <= ACC_WAIT;
    end else if (!accActive) begin
      accQ <= ACC_WAIT;
    end else begin
      unique case (accQ)
        ACC_WAIT: if (atnS || rxInReady) accQ <= ACC_RDY;
        ACC_RDY:  if (davS) accQ <= ACC_DONE;
        ACC_DONE: if (!davS) accQ <= ACC_WAIT;
        default:  accQ <= ACC_WAIT;
      endcase
    end
  end

  assign take    = accActive && (accQ == ACC_RDY) && davS;
  assign cmdTake = take && atnS;
  assign rxPush  = take && !atnS;

  // ------------------------------------------------------------------
  // command decode under attention
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ladQ      <= 1'b0;
      tadQ      <= 1'b0;
      mineQ     <= 1'b0;
      secValidQ <= 1'b0;
      secCodeQ  <= '0;
      devClrQ   <= 1'b0;
    end else begin
      secValidQ <= 1'b0;
      devClrQ   <= 1'b0;
      if (ifcS) begin
        ladQ  <= 1'b0;
        tadQ  <= 1'b0;
        mineQ <= 1'b0;
      end else if (cmdTake) begin
        if (cmd == CMD_UNLISTEN) begin
          ladQ  <= 1'b0;
          mineQ <= 1'b0;
        end else if (cmd == CMD_UNTALK) begin
          tadQ  <= 1'b0;
          mineQ <= 1'b0;
        end else if (cmd[6:5] == GRP_LISTEN) begin
          if (cmd[4:0] == addrQ) ladQ <= 1'b1;
          mineQ <= (cmd[4:0] == addrQ);
        end else if (cmd[6:5] == GRP_TALK) begin
          tadQ  <= (cmd[4:0] == addrQ);
          mineQ <= (cmd[4:0] == addrQ);
        end else if (cmd[6:5] == GRP_SECONDARY) begin
          if (mineQ) begin
            secValidQ <= 1'b1;
            secCodeQ  <= cmd[4:0];
          end
        end else if (cmd[6:4] == UNIV_PREFIX && cmd[3:0] == UNIV_DCL) begin
          devClrQ  <= 1'b1;
          secCodeQ <= '0;
          mineQ    <= 1'b0;
        end
      end
    end
  end

  // front panel or bus programming follows the remote line
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) remoteQ <= 1'b0;
    else remoteQ <= renS;
  end

  // ------------------------------------------------------------------
  // source handshake
  // ------------------------------------------------------------------
  // talker aborts at once when attention returns, freeing the data lines
  assign talkOk = tadQ && !atnS && !ifcS;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      srcQ     <= SRC_IDLE;
      txByteQ  <= '0;
      txEoiQ   <= 1'b0;
      txReadyQ <= 1'b0;
    end else if (!talkOk) begin
      srcQ     <= SRC_IDLE;
      txReadyQ <= 1'b0;
    end else begin
      unique case (srcQ)
        SRC_IDLE: begin
          txReadyQ <= !(txValid && txReadyQ);
          if (txValid && txReadyQ) begin
            txByteQ <= txData;
            txEoiQ  <= txLast;
            srcQ    <= SRC_SETUP;
          end
        end
        SRC_SETUP: if (!nrfdS && ndacS) srcQ <= SRC_DAV;
        SRC_DAV:   if (!ndacS) srcQ <= SRC_IDLE;
        default:   srcQ <= SRC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // line drive
  // ------------------------------------------------------------------
  // registered so every pull-down comes from a flip-flop
  always_comb begin
    oeD = '0;
    if (srcQ != SRC_IDLE) begin
      oeD[L_DIO0 +: 8] = txByteQ;
      oeD[L_EOI]       = txEoiQ;
    end
    oeD[L_DAV] = (srcQ == SRC_DAV);
    if (accActive) begin
      oeD[L_NRFD] = (accQ != ACC_RDY);
      oeD[L_NDAC] = (accQ != ACC_DONE);
    end
    if (ppS && serviceReq) oeD[L_DIO0 + int'(addrQ[2:0])] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) oeQ <= '0;
    else oeQ <= oeD;
  end

  assign bus.devO  = '0;
  assign bus.devOe = oeQ;

  // ------------------------------------------------------------------
  // receive buffer
  // ------------------------------------------------------------------
  // stalls the acceptor while full, so the slowest consumer sets the rate
  fifo_buf #(.WIDTH(RX_WIDTH), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .flush    (devClrQ || ifcS),
    .inValid  (rxPush),
    .inData   ({eoiS, dioS}),
    .inReady  (rxInReady),
    .outValid (rxValid),
    .outData  (rxWord),
    .outReady (rxReady)
  );

  assign rxData         = rxWord[7:0];
  assign rxLast         = rxWord[8];
  assign txReady        = txReadyQ;
  assign listenActive   = ladQ;
  assign talkActive     = tadQ;
  assign remoteMode     = remoteQ;
  assign secondaryValid = secValidQ;
  assign secondaryCode  = secCodeQ;
  assign devClear       = devClrQ;
  assign ifcActive      = s2Q[L_IFC];
endmodule : ibus_device

// ==== hw/ibus_if.sv ====
// Purpose : open-drain instrument bus joining the device end and the controller end
// Assumes : each party drives an enable per line; the out value is always low
// Notes   : a line reads low while any party enables it
`timescale 1ns/10ps
interface ibus_if import ibus_pkg::*; ();
  logic [NLINES-1:0] devO;
  logic [NLINES-1:0] devOe;
  logic [NLINES-1:0] ctlO;
  logic [NLINES-1:0] ctlOe;
  logic [NLINES-1:0] lineLow;

  // wired-or of every pull-down on the cable
  assign lineLow = devOe | ctlOe;

  modport device (output devO, output devOe, input lineLow);
  modport ctrl   (output ctlO, output ctlOe, input lineLow);
endinterface : ibus_if

// ==== hw/ibus_pkg.sv ====
// Purpose : shared constants and types for the instrument bus port
// Assumes : lines are carried as one vector, a set bit meaning the line is pulled low
// Notes   : data lines use negative logic, so a pulled-low line carries a logic one
package ibus_pkg;

  // ------------------------------------------------------------------
  // line positions in the bus vector
  // ------------------------------------------------------------------
  localparam int NLINES = 15;
  localparam int L_DIO0 = 0;  // eight data lines at 7:0
  localparam int L_DAV  = 8;
  localparam int L_NRFD = 9;
  localparam int L_NDAC = 10;
  localparam int L_EOI  = 11;
  localparam int L_ATN  = 12;
  localparam int L_IFC  = 13;
  localparam int L_REN  = 14;

  // ------------------------------------------------------------------
  // command byte encodings, parity bit 7 ignored
  // ------------------------------------------------------------------
  localparam int              ADDR_W        = 5;
  localparam logic [6:0]      CMD_UNLISTEN  = 7'h3F;
  localparam logic [6:0]      CMD_UNTALK    = 7'h5F;
  localparam logic [1:0]      GRP_LISTEN    = 2'h1;
  localparam logic [1:0]      GRP_TALK      = 2'h2;
  localparam logic [1:0]      GRP_SECONDARY = 2'h3;
  localparam logic [2:0]      UNIV_PREFIX   = 3'h1;
  localparam logic [3:0]      UNIV_DCL      = 4'h4;

  // ------------------------------------------------------------------
  // buffering and timing
  // ------------------------------------------------------------------
  localparam int         FIFO_DEPTH  = 8;
  localparam int         RX_WIDTH    = 9;      // end flag above the data byte
  // cycles before a poll is sampled; must cover the round trip of one oe flop
  // and a two-stage sync on each side, or pollData shows the idle lines
  localparam logic [2:0] POLL_SETTLE = 3'h6;

  // ------------------------------------------------------------------
  // handshake state machines
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_WAIT = 2'b00,
    ACC_RDY  = 2'b01,
    ACC_DONE = 2'b10
  } acc_e;

  typedef enum logic [1:0] {
    SRC_IDLE  = 2'b00,
    SRC_SETUP = 2'b01,
    SRC_DAV   = 2'b10
  } src_e;

endpackage : ibus_pkg
